// File: common/err_report_pkg.sv
// package: register map, field positions and types of the error reporting block
package err_report_pkg;
   localparam int ADDR_W = 6;
   localparam int CRED_DATA_W = 12;
   localparam int CRED_HDR_W = 8;
   // register byte offsets
   localparam logic [5:0] OFF_UNCOR_STAT = 6'h00;
   localparam logic [5:0] OFF_COR_STAT   = 6'h04;
   localparam logic [5:0] OFF_DEV_STAT   = 6'h08;
   localparam logic [5:0] OFF_CTRL       = 6'h0c;
   localparam logic [5:0] OFF_SEVERITY   = 6'h10;
   localparam logic [5:0] OFF_SEC_STAT   = 6'h14;
   localparam logic [5:0] OFF_IRQ_STAT   = 6'h18;
   localparam logic [5:0] OFF_IRQ_MASK   = 6'h1c;
   // uncorrectable status / severity bits
   localparam int UB_RXO  = 0;
   localparam int UB_FLOW_CONTROL_PROTOCOL_ERROR = 1;
   localparam int UB_DATA_LINK_PROTOCOL_ERROR = 2;
   localparam int UB_UDE  = 3;
   localparam int UB_PERR = 4;
   localparam int UNCOR_W = 5;
   // correctable status bits
   localparam int CB_TLP  = 0;
   localparam int CB_DLLP = 1;
   localparam int CB_RRO  = 2;
   localparam int CB_RTO  = 3;
   localparam int COR_W   = 4;
   // device status bits
   localparam int DB_COR = 0;
   localparam int DB_NFT = 1;
   localparam int DB_FTL = 2;
   localparam int DB_SSE = 3;
   localparam int DB_DPE = 4;
   localparam int DB_MDP = 5;
   localparam int DEV_W  = 6;
   // control bits
   localparam int CT_SYSTEM_ERROR_ENABLE = 0;
   localparam int CT_PERESP  = 1;
   localparam int CT_MSG_EN  = 2;
   localparam int CTRL_W     = 3;
   // irq status: 0 correctable, 1 nonfatal, 2 fatal
   localparam int IRQ_W = 3;
   localparam logic [CRED_DATA_W-1:0] MAX_DATA_CRED = 12'h7ff;
   localparam logic [CRED_HDR_W-1:0]  MAX_HDR_CRED  = 8'h7f;
   localparam logic [CRED_DATA_W-1:0] MIN_DATA_CRED = 12'h001;
   localparam logic [CRED_HDR_W-1:0]  MIN_HDR_CRED  = 8'h01;
   localparam logic [UNCOR_W-1:0] SEV_RESET = 5'h03;
   localparam logic [CTRL_W-1:0]  CTRL_RESET = 3'h0;

   typedef enum logic [1:0] {MSG_NONE, MSG_COR, MSG_NONFATAL, MSG_FATAL} msg_kind_t;

   typedef struct packed {
      logic rx_overflow;
      logic ack_seq_bad;
      logic tlp_edb_lcrc_bad;
      logic tlp_end_lcrc_bad;
      logic tlp_end_field_bad;
      logic dllp_crc_bad;
      logic replay_rollover;
      logic replay_timeout;
   } link_evt_t;

   typedef struct packed {
      logic                   init_valid;
      logic                   update_valid;
      logic                   is_hdr;
      logic [CRED_DATA_W-1:0] value;
   } fc_evt_t;

   typedef struct packed {
      logic imm_data_err;
      logic nonposted_wr;
      logic perr_in;
   } pci_evt_t;
endpackage : err_report_pkg

// File: hdl/err_report.sv
// error detection and reporting block for the link and pci data paths
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module err_report (
   input  wire logic                              CLK,
   input  wire logic                              RESETN,
   input  wire logic                              CE,
   input  wire logic [err_report_pkg::ADDR_W-1:0] WB_ADR_I,
   input  wire logic [31:0]                       WB_DAT_I,
   input  wire logic [3:0]                        WB_SEL_I,
   input  wire logic                              WB_WE_I,
   input  wire logic                              WB_CYC_I,
   input  wire logic                              WB_STB_I,
   output logic      [31:0]                       WB_DAT_O,
   output logic                                   WB_ACK_O,
   input  wire err_report_pkg::link_evt_t         LINK_EVT,
   input  wire err_report_pkg::fc_evt_t           FC_EVT,
   input  wire err_report_pkg::pci_evt_t          PCI_EVT,
   output err_report_pkg::msg_kind_t              MSG_KIND,
   output logic                                   MSG_VALID,
   output logic                                   PCI_PARITY_ERROR_PIN_N_O,
   output logic                                   PCI_PARITY_ERROR_PIN_OE,
   output logic                                   IRQ
);
   import err_report_pkg::*;

   logic [UNCOR_W-1:0] uncor_reg, sev_reg;
   logic [COR_W-1:0]   cor_reg;
   logic [DEV_W-1:0]   dev_reg;
   logic [CTRL_W-1:0]  ctrl_reg;
   logic [1:0]         sec_reg;
   logic [IRQ_W-1:0]   irq_stat_reg, irq_mask_reg;
   logic               hdr_inf_reg, data_inf_reg;
   logic               perr_pin_reg;
   logic               perr_pin_n_reg;
   msg_kind_t          msg_kind_reg;
   logic               msg_valid_reg;
   logic [31:0]        dat_reg;
   logic               ack_reg, irq_reg;

   // bus decode
   wire bus_req = WB_CYC_I & WB_STB_I & ~ack_reg;
   wire bus_wr  = bus_req & WB_WE_I & WB_SEL_I[0];
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
      hit = ({a[ADDR_W-1:2], 2'b00} == off);
   endfunction : hit
   wire wr_uncor = bus_wr & hit(WB_ADR_I, OFF_UNCOR_STAT);
   wire wr_cor   = bus_wr & hit(WB_ADR_I, OFF_COR_STAT);
   wire wr_dev   = bus_wr & hit(WB_ADR_I, OFF_DEV_STAT);
   wire wr_ctrl  = bus_wr & hit(WB_ADR_I, OFF_CTRL);
   wire wr_sev   = bus_wr & hit(WB_ADR_I, OFF_SEVERITY);
   wire wr_sec   = bus_wr & hit(WB_ADR_I, OFF_SEC_STAT);
   wire wr_istat = bus_wr & hit(WB_ADR_I, OFF_IRQ_STAT);
   wire wr_imask = bus_wr & hit(WB_ADR_I, OFF_IRQ_MASK);

   // flow control checks
   wire fc_hdr_low  = FC_EVT.init_valid & FC_EVT.is_hdr & (FC_EVT.value != '0)
                      & (FC_EVT.value[CRED_HDR_W-1:0] < MIN_HDR_CRED);
   wire fc_data_low = FC_EVT.init_valid & ~FC_EVT.is_hdr & (FC_EVT.value != '0)
                      & (FC_EVT.value < MIN_DATA_CRED);
   wire fc_hdr_big  = (FC_EVT.init_valid | FC_EVT.update_valid) & FC_EVT.is_hdr
                      & ((FC_EVT.value[CRED_DATA_W-1:CRED_HDR_W] != '0)
                         | (FC_EVT.value[CRED_HDR_W-1:0] > MAX_HDR_CRED));
   wire fc_data_big = (FC_EVT.init_valid | FC_EVT.update_valid) & ~FC_EVT.is_hdr
                      & (FC_EVT.value > MAX_DATA_CRED);
   wire fc_inf_bad  = FC_EVT.update_valid & (FC_EVT.value != '0)
                      & (FC_EVT.is_hdr ? hdr_inf_reg : data_inf_reg);
   wire flow_control_protocol_error_evt    = fc_hdr_low | fc_data_low | fc_hdr_big | fc_data_big | fc_inf_bad;

   // event vectors
   wire ude_evt  = PCI_EVT.imm_data_err;
   wire perr_evt = PCI_EVT.nonposted_wr & PCI_EVT.perr_in;
   wire [UNCOR_W-1:0] uncor_evt = {perr_evt, ude_evt, LINK_EVT.ack_seq_bad,
                                   flow_control_protocol_error_evt, LINK_EVT.rx_overflow};
   wire [COR_W-1:0] cor_evt = {LINK_EVT.replay_timeout, LINK_EVT.replay_rollover,
                               LINK_EVT.dllp_crc_bad,
                               LINK_EVT.tlp_edb_lcrc_bad | LINK_EVT.tlp_end_lcrc_bad
                               | LINK_EVT.tlp_end_field_bad};
   wire fatal_evt    = |(uncor_evt & sev_reg);
   wire nonfatal_evt = |(uncor_evt & ~sev_reg);
   wire cor_any      = |cor_evt;
   wire msg_en       = ctrl_reg[CT_MSG_EN];
   wire send_uncor   = msg_en & (fatal_evt | nonfatal_evt);
   wire sse_evt      = send_uncor & ctrl_reg[CT_SYSTEM_ERROR_ENABLE];
   wire peresp       = ctrl_reg[CT_PERESP];
   wire mdp_evt      = (ude_evt | perr_evt) & peresp;
   msg_kind_t msg_next;
   assign msg_next = fatal_evt ? MSG_FATAL : nonfatal_evt ? MSG_NONFATAL :
                     cor_any ? MSG_COR : MSG_NONE;
   wire [DEV_W-1:0] dev_evt = {mdp_evt, ude_evt, sse_evt, fatal_evt, nonfatal_evt, cor_any};
   wire [IRQ_W-1:0] irq_evt = {fatal_evt, nonfatal_evt, cor_any};

   // set wins over write-one-to-clear
   function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] set,
                                       input logic clr);
      w1c = (cur & ~(clr ? WB_DAT_I : 32'h0)) | set;
   endfunction : w1c

   wire [31:0] rd_mux =
      hit(WB_ADR_I, OFF_UNCOR_STAT) ? {27'h0, uncor_reg} :
      hit(WB_ADR_I, OFF_COR_STAT)   ? {28'h0, cor_reg} :
      hit(WB_ADR_I, OFF_DEV_STAT)   ? {26'h0, dev_reg} :
      hit(WB_ADR_I, OFF_CTRL)       ? {29'h0, ctrl_reg} :
      hit(WB_ADR_I, OFF_SEVERITY)   ? {27'h0, sev_reg} :
      hit(WB_ADR_I, OFF_SEC_STAT)   ? {30'h0, sec_reg} :
      hit(WB_ADR_I, OFF_IRQ_STAT)   ? {29'h0, irq_stat_reg} :
      hit(WB_ADR_I, OFF_IRQ_MASK)   ? {29'h0, irq_mask_reg} : 32'h0;

   // full-width next values, sliced where they are stored
   wire [31:0] uncor_wide_next = w1c(32'(uncor_reg), 32'(uncor_evt), wr_uncor);
   wire [31:0] cor_wide_next   = w1c(32'(cor_reg), 32'(cor_evt), wr_cor);
   wire [31:0] dev_wide_next   = w1c(32'(dev_reg), 32'(dev_evt), wr_dev);
   wire [31:0] sec_wide_next   = w1c(32'(sec_reg), {30'h0, perr_evt, ude_evt}, wr_sec);
   wire [31:0] istat_wide_next = w1c(32'(irq_stat_reg), 32'(irq_evt), wr_istat);
   wire [IRQ_W-1:0] irq_stat_next = istat_wide_next[IRQ_W-1:0];

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         uncor_reg    <= '0;
         cor_reg      <= '0;
         dev_reg      <= '0;
         sec_reg      <= '0;
         ctrl_reg     <= CTRL_RESET;
         sev_reg      <= SEV_RESET;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         irq_reg      <= 1'b0;
      end else if (CE) begin
         uncor_reg    <= uncor_wide_next[UNCOR_W-1:0];
         cor_reg      <= cor_wide_next[COR_W-1:0];
         dev_reg      <= dev_wide_next[DEV_W-1:0];
         sec_reg      <= sec_wide_next[1:0];
         irq_stat_reg <= irq_stat_next;
         if (wr_ctrl) ctrl_reg <= WB_DAT_I[CTRL_W-1:0];
         if (wr_sev) sev_reg <= WB_DAT_I[UNCOR_W-1:0];
         if (wr_imask) irq_mask_reg <= WB_DAT_I[IRQ_W-1:0];
         irq_reg      <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // infinite credit memory: zero value on initial advertisement
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         hdr_inf_reg  <= 1'b0;
         data_inf_reg <= 1'b0;
      end else if (CE && FC_EVT.init_valid) begin
         if (FC_EVT.is_hdr) hdr_inf_reg <= (FC_EVT.value == '0);
         else data_inf_reg <= (FC_EVT.value == '0);
      end
   end

   // message, parity pin and bus answer
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         msg_kind_reg  <= MSG_NONE;
         msg_valid_reg <= 1'b0;
         perr_pin_reg  <= 1'b0;
         perr_pin_n_reg <= 1'b1;
         ack_reg       <= 1'b0;
         dat_reg       <= 32'h0;
      end else if (CE) begin
         msg_kind_reg  <= msg_next;
         msg_valid_reg <= msg_en & (msg_next != MSG_NONE);
         perr_pin_reg  <= ude_evt & peresp;
         perr_pin_n_reg <= ~(ude_evt & peresp);
         ack_reg       <= bus_req;
         dat_reg       <= bus_req ? rd_mux : 32'h0;
      end
   end

   assign WB_DAT_O                 = dat_reg;
   assign WB_ACK_O                 = ack_reg;
   assign MSG_KIND                 = msg_kind_reg;
   assign MSG_VALID                = msg_valid_reg;
   assign PCI_PARITY_ERROR_PIN_N_O = perr_pin_n_reg;
   assign PCI_PARITY_ERROR_PIN_OE  = perr_pin_reg;
   assign IRQ                      = irq_reg;

   property p_rxo;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.rx_overflow) |=> uncor_reg[UB_RXO];
   endproperty
   a_rxo: assert property (p_rxo) else $error("rx overflow not recorded");
   property p_fc_big;
      @(posedge CLK) disable iff (!RESETN)
      (CE && FC_EVT.update_valid && !FC_EVT.is_hdr && FC_EVT.value > MAX_DATA_CRED)
      |=> uncor_reg[UB_FLOW_CONTROL_PROTOCOL_ERROR];
   endproperty
   a_fc_big: assert property (p_fc_big) else $error("data credit overrun missed");
   property p_inf;
      @(posedge CLK) disable iff (!RESETN)
      (CE && FC_EVT.init_valid && FC_EVT.is_hdr && FC_EVT.value == '0) ##1
      (CE && FC_EVT.update_valid && FC_EVT.is_hdr && FC_EVT.value != '0) |=> uncor_reg[UB_FLOW_CONTROL_PROTOCOL_ERROR];
   endproperty
   a_inf: assert property (p_inf) else $error("infinite credit update missed");
   property p_data_link_protocol_error;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.ack_seq_bad) |=> uncor_reg[UB_DATA_LINK_PROTOCOL_ERROR] && (dev_reg[DB_FTL] || dev_reg[DB_NFT]);
   endproperty
   a_data_link_protocol_error: assert property (p_data_link_protocol_error) else $error("link protocol error missed");
   property p_btlp;
      @(posedge CLK) disable iff (!RESETN)
      (CE && (LINK_EVT.tlp_end_lcrc_bad || LINK_EVT.tlp_end_field_bad))
      |=> cor_reg[CB_TLP] && dev_reg[DB_COR];
   endproperty
   a_btlp: assert property (p_btlp) else $error("bad tlp missed");
   property p_sse;
      @(posedge CLK) disable iff (!RESETN)
      $rose(dev_reg[DB_SSE]) |-> $past(ctrl_reg[CT_SYSTEM_ERROR_ENABLE]) && $past(msg_en);
   endproperty
   a_sse: assert property (p_sse) else $error("system error without cause");
   property p_perr;
      @(posedge CLK) disable iff (!RESETN)
      PCI_PARITY_ERROR_PIN_OE |-> $past(peresp) && $past(ude_evt) && dev_reg[DB_DPE];
   endproperty
   a_perr: assert property (p_perr) else $error("parity pin without cause");
   property p_sev;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.replay_timeout && uncor_evt == '0) |=> cor_reg[CB_RTO] && MSG_KIND == MSG_COR;
   endproperty
   a_sev: assert property (p_sev) else $error("replay timeout mishandled");

   // severity flag follows an rx overflow link event
   property p_rxo_sev;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.rx_overflow)
      |=> (dev_reg[DB_FTL] || dev_reg[DB_NFT]);
   endproperty
   a_rxo_sev: assert property (p_rxo_sev) else $error("overflow severity missing");

   // header credit overrun on initial or update advertisement
   property p_hdr_big;
      @(posedge CLK) disable iff (!RESETN)
      (CE && (FC_EVT.init_valid || FC_EVT.update_valid) && FC_EVT.is_hdr
       && FC_EVT.value > CRED_DATA_W'(MAX_HDR_CRED))
      |=> uncor_reg[UB_FLOW_CONTROL_PROTOCOL_ERROR];
   endproperty
   a_hdr_big: assert property (p_hdr_big) else $error("header credit overrun missed");

   // edb terminated tlp with bad lcrc
   property p_edb;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.tlp_edb_lcrc_bad)
      |=> cor_reg[CB_TLP] && dev_reg[DB_COR];
   endproperty
   a_edb: assert property (p_edb) else $error("edb tlp error missed");

   // end terminated tlp with an invalid field
   property p_field;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.tlp_end_field_bad)
      |=> cor_reg[CB_TLP] && dev_reg[DB_COR];
   endproperty
   a_field: assert property (p_field) else $error("tlp field error missed");

   // dllp crc error
   property p_dllp;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.dllp_crc_bad)
      |=> cor_reg[CB_DLLP] && dev_reg[DB_COR];
   endproperty
   a_dllp: assert property (p_dllp) else $error("dllp crc error missed");

   // replay counter rollover
   property p_rro;
      @(posedge CLK) disable iff (!RESETN)
      (CE && LINK_EVT.replay_rollover)
      |=> cor_reg[CB_RRO] && dev_reg[DB_COR];
   endproperty
   a_rro: assert property (p_rro) else $error("replay rollover missed");

   // system error set whenever an uncorrectable message goes out with the enable on
   property p_sse_set;
      @(posedge CLK) disable iff (!RESETN)
      (CE && send_uncor && ctrl_reg[CT_SYSTEM_ERROR_ENABLE])
      |=> dev_reg[DB_SSE];
   endproperty
   a_sse_set: assert property (p_sse_set) else $error("system error not set");

   // pci data error on an immediate completer response
   property p_ude;
      @(posedge CLK) disable iff (!RESETN)
      (CE && ude_evt)
      |=> dev_reg[DB_DPE] && sec_reg[0] && (dev_reg[DB_FTL] || dev_reg[DB_NFT]);
   endproperty
   a_ude: assert property (p_ude) else $error("pci data error missed");

   // master data parity flag only with parity response enabled
   property p_mdp;
      @(posedge CLK) disable iff (!RESETN)
      $rose(dev_reg[DB_MDP]) |-> $past(peresp);
   endproperty
   a_mdp: assert property (p_mdp) else $error("master parity flag without enable");

   // target parity error during a nonposted write
   property p_secondary_parity_asserted_status;
      @(posedge CLK) disable iff (!RESETN)
      (CE && perr_evt)
      |=> sec_reg[1] && (dev_reg[DB_FTL] || dev_reg[DB_NFT]);
   endproperty
   a_secondary_parity_asserted_status: assert property (p_secondary_parity_asserted_status) else $error("target parity error missed");

   // fatal severity picks the fatal flag and message kind
   property p_fatal;
      @(posedge CLK) disable iff (!RESETN)
      (CE && (|(uncor_evt & sev_reg)))
      |=> dev_reg[DB_FTL] && MSG_KIND == MSG_FATAL;
   endproperty
   a_fatal: assert property (p_fatal) else $error("fatal severity ignored");

   // nonfatal severity picks the nonfatal flag
   property p_nonfatal;
      @(posedge CLK) disable iff (!RESETN)
      (CE && (|(uncor_evt & ~sev_reg)))
      |=> dev_reg[DB_NFT];
   endproperty
   a_nonfatal: assert property (p_nonfatal) else $error("nonfatal severity ignored");

   // messages only while enabled
   property p_msg;
      @(posedge CLK) disable iff (!RESETN)
      MSG_VALID |-> $past(msg_en) && MSG_KIND != MSG_NONE;
   endproperty
   a_msg: assert property (p_msg) else $error("message while disabled");

   // clock enable low freezes state
   property p_ce;
      @(posedge CLK) disable iff (!RESETN)
      !CE |=> $stable(uncor_reg) && $stable(cor_reg) && $stable(dev_reg) && $stable(WB_ACK_O);
   endproperty
   a_ce: assert property (p_ce) else $error("state moved while frozen");

   // bus answer is a single cycle pulse
   property p_ack;
      @(posedge CLK) disable iff (!RESETN)
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack held too long");
endmodule : err_report

// File: dv/pci_agent_model.sv
// pci side agent model that raises data error events toward the bridge
`timescale 1ns/1ps
module pci_agent_model (
   input  wire logic                CLK,
   input  wire logic                RESETN,
   input  wire logic                imm_req,
   input  wire logic                wr_req,
   output err_report_pkg::pci_evt_t evt
);
   import err_report_pkg::*;
   logic [1:0] cnt_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_reg <= 2'h0;
      end else if (wr_req) begin
         cnt_reg <= 2'h3;
      end else if (cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end
   end
   assign evt.imm_data_err = imm_req;
   assign evt.nonposted_wr = (cnt_reg != 2'h0);
   // target flags parity once in the middle of the write
   assign evt.perr_in      = (cnt_reg == 2'h2);
endmodule : pci_agent_model

// File: dv/tb.sv
// testbench for the error reporting block
`timescale 1ns/1ps
module tb;
   import err_report_pkg::*;
   logic              clk, resetn, cyc, stb, we, ack, msg_valid, pin_n, pin_oe, irq;
   logic              imm_req, wr_req, ce;
   logic [ADDR_W-1:0] adr;
   logic [31:0]       dati, dato, q, eu, ec, ed;
   logic [3:0]        sel;
   link_evt_t         link;
   fc_evt_t           fc;
   pci_evt_t          pci;
   msg_kind_t         msg_kind, mk;
   int                err_count, num_checks;

   err_report err_report_i (.CLK(clk), .RESETN(resetn), .CE(ce), .WB_ADR_I(adr),
      .WB_DAT_I(dati), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_DAT_O(dato), .WB_ACK_O(ack), .LINK_EVT(link), .FC_EVT(fc), .PCI_EVT(pci),
      .MSG_KIND(msg_kind), .MSG_VALID(msg_valid), .PCI_PARITY_ERROR_PIN_N_O(pin_n),
      .PCI_PARITY_ERROR_PIN_OE(pin_oe), .IRQ(irq));
   pci_agent_model pci_agent_model_i (.CLK(clk), .RESETN(resetn), .imm_req(imm_req),
      .wr_req(wr_req), .evt(pci));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dati <= d;
      sel <= s;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20) chk("ack", 32'h0, 32'h1);
   endtask : wb

   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0, 4'hf);
      chk("reg", q, exp);
   endtask : rd

   task automatic clear_all();
      wb(1'b1, OFF_UNCOR_STAT, 32'hffffffff, 4'hf);
      wb(1'b1, OFF_COR_STAT, 32'hffffffff, 4'hf);
      wb(1'b1, OFF_DEV_STAT, 32'hffffffff, 4'hf);
      wb(1'b1, OFF_SEC_STAT, 32'hffffffff, 4'hf);
      wb(1'b1, OFF_IRQ_STAT, 32'hffffffff, 4'hf);
   endtask : clear_all

   task automatic link_one(input int i);
      @(posedge clk);
      link <= link_evt_t'(8'h80 >> i);
      @(posedge clk);
      link <= '0;
      #1;
      chk("msg_valid", msg_valid, 32'h1);
      chk("msg_kind", msg_kind, mk);
      @(posedge clk);
      #1;
      chk("irq", irq, 32'h1);
      rd(OFF_UNCOR_STAT, eu);
      rd(OFF_COR_STAT, ec);
      rd(OFF_DEV_STAT, ed);
      clear_all();
   endtask : link_one

   task automatic fc_one(input logic ini, input logic upd, input logic hdr,
                         input logic [11:0] v, input logic bad);
      @(posedge clk);
      fc <= '{ini, upd, hdr, v};
      @(posedge clk);
      fc <= '0;
      rd(OFF_UNCOR_STAT, 32'(bad) << UB_FLOW_CONTROL_PROTOCOL_ERROR);
      rd(OFF_DEV_STAT, bad ? 32'h0c : 32'h0);
      clear_all();
   endtask : fc_one

   task automatic pci_one(input logic imm, input logic pr);
      wb(1'b1, OFF_CTRL, {29'h0, 1'b1, pr, 1'b0}, 4'hf);
      @(posedge clk);
      imm_req <= imm;
      wr_req <= !imm;
      @(posedge clk);
      imm_req <= 1'b0;
      wr_req <= 1'b0;
      #1;
      chk("pin_n", pin_n, imm ? !pr : 1'b1);
      chk("pin_oe", pin_oe, imm & pr);
      repeat (4) @(posedge clk);
      rd(OFF_UNCOR_STAT, imm ? 32'h1 << UB_UDE : 32'h1 << UB_PERR);
      rd(OFF_SEC_STAT, imm ? 32'h1 : 32'h2);
      wb(1'b0, OFF_DEV_STAT, 32'h0, 4'hf);
      chk("dev", q, 32'h2 | (32'(imm) << DB_DPE) | (32'(pr) << DB_MDP));
      clear_all();
   endtask : pci_one

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out

   initial begin
      resetn = 1'b0;
      {cyc, stb, we, imm_req, wr_req} = '0;
      ce = 1'b1;
      {adr, dati, sel, link, fc} = '0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(OFF_SEVERITY, 32'h3);
      rd(OFF_CTRL, 32'h0);
      rd(6'h20, 32'h0);
      wb(1'b1, OFF_CTRL, 32'h7, 4'he);
      rd(OFF_CTRL, 32'h0);
      wb(1'b1, OFF_IRQ_MASK, 32'h7, 4'hf);
      wb(1'b1, OFF_CTRL, 32'h6, 4'hf);
      for (int i = 0; i < 8; i++) begin
         eu = (i == 0) ? 32'h1 << UB_RXO : (i == 1) ? 32'h1 << UB_DATA_LINK_PROTOCOL_ERROR : 32'h0;
         ec = (i < 2) ? 32'h0 : (i < 5) ? 32'h1 << CB_TLP : 32'h1 << (CB_DLLP + i - 5);
         ed = (i == 0) ? 32'h1 << DB_FTL : (i == 1) ? 32'h1 << DB_NFT : 32'h1 << DB_COR;
         mk = (i == 0) ? MSG_FATAL : (i == 1) ? MSG_NONFATAL : MSG_COR;
         link_one(i);
      end
      wb(1'b1, OFF_SEVERITY, 32'h0, 4'hf);
      eu = 32'h1 << UB_RXO;
      ec = 32'h0;
      ed = 32'h1 << DB_NFT;
      mk = MSG_NONFATAL;
      link_one(0);
      wb(1'b1, OFF_SEVERITY, 32'h3, 4'hf);
      wb(1'b1, OFF_CTRL, 32'h7, 4'hf);
      fc_one(1'b1, 1'b0, 1'b0, 12'h7ff, 1'b0);
      fc_one(1'b1, 1'b0, 1'b1, 12'h07f, 1'b0);
      fc_one(1'b1, 1'b0, 1'b0, 12'h800, 1'b1);
      fc_one(1'b1, 1'b0, 1'b1, 12'h080, 1'b1);
      fc_one(1'b1, 1'b0, 1'b0, 12'h000, 1'b0);
      fc_one(1'b0, 1'b1, 1'b0, 12'h005, 1'b1);
      for (int k = 0; k < 4; k++) pci_one(k[1], k[0]);
      wb(1'b1, OFF_IRQ_MASK, 32'h0, 4'hf);
      @(posedge clk);
      link <= link_evt_t'(8'h01);
      @(posedge clk);
      link <= '0;
      repeat (3) @(posedge clk);
      chk("irq_masked", irq, 32'h0);
      wb(1'b1, OFF_IRQ_MASK, 32'h1, 4'hf);
      repeat (2) @(posedge clk);
      chk("irq_on", irq, 32'h1);
      wb(1'b1, OFF_IRQ_STAT, 32'h1, 4'hf);
      repeat (2) @(posedge clk);
      chk("irq_off", irq, 32'h0);
      clear_all();
      @(posedge clk);
      ce <= 1'b0;
      link <= link_evt_t'(8'h01);
      @(posedge clk);
      link <= '0;
      @(posedge clk);
      ce <= 1'b1;
      rd(OFF_COR_STAT, 32'h0);
      close_out();
   end

   initial begin
      #2000000;
      err_count++;
      close_out();
   end
endmodule : tb
